//--- hdl/fcsa_device_end.sv
// Our own choices: the address map and strobed register access.
`timescale 1ns/10ps
// Functional notes
// - Map readable always, writable only unlocked
// - Data-only sector faults program-space accesses
// - Mixed sector allows data and program
// - Map loaded from array at reset
// - Buffer-empty flag; write one launches
// - Command writes ignored while buffer full
// - Buffer-empty interrupt when flag and enable
// - Complete flag follows engine, writes ignored
// - Complete interrupt when flag and enable
// - Protection violation on protected program/erase
// - Access error on bad sequence, write-one-clear
// - Access error flag blocks command launch
// - Blank flag set when verify finds erased
// - Ones clear violation, error and blank flags; a write with bit seven zero aborts a pending sequence and sets error
// - Seven-bit code; invalid code sets error
// - Command register bit seven reads zero
// - Decode program, erase and verify codes
// - All-ones verify reports through blank flag
// - Array word, code, launch, nothing between
// - Page erase drops low ten address bits
module fcsa_device_end (
  input  wire logic                        clk_sys,
  input  wire logic                        reset_n,
  fcsa_bus_if.device                       bus,
  input  wire logic [fcsa_pkg::DATA_W-1:0] sectorProtect,
  output logic      [fcsa_pkg::ADDR_W-1:0] arrayRdAddr,
  input  wire logic [fcsa_pkg::DATA_W-1:0] arrayRdData,
  output logic                             arrayLoadReq,
  output logic                             flashStart,
  output logic      [fcsa_pkg::CMD_W-1:0]  flashCmd,
  output logic      [fcsa_pkg::ADDR_W-1:0] flashAddr,
  output logic      [fcsa_pkg::DATA_W-1:0] flashData,
  input  wire logic                        flashDone,
  input  wire logic                        flashBlank
);
  typedef enum logic [1:0] {SEQ_EMPTY, SEQ_DATA, SEQ_CMD, SEQ_HELD} fcsa_seq_type;

  fcsa_seq_type                  seq_reg;
  logic [fcsa_pkg::DATA_W-1:0]   dataMap_reg;
  logic                          loadPending_reg;
  logic                          lock_reg;
  logic                          cbeIrqEn_reg;
  logic                          ccIrqEn_reg;
  logic                          access_error_flag_reg;
  logic                          protViol_reg;
  logic                          blank_reg;
  logic [fcsa_pkg::CMD_W-1:0]    cmdCode_reg;
  logic [fcsa_pkg::ADDR_W-1:0]   bufAddr_reg;
  logic [fcsa_pkg::DATA_W-1:0]   bufData_reg;
  logic                          engineBusy_reg;
  logic                          start_reg;
  logic [fcsa_pkg::CMD_W-1:0]    engCmd_reg;
  logic [fcsa_pkg::ADDR_W-1:0]   engAddr_reg;
  logic [fcsa_pkg::DATA_W-1:0]   engData_reg;
  logic                          ack_reg;
  logic                          err_reg;
  logic [fcsa_pkg::DATA_W-1:0]   rdata_reg;

  logic                          regWrite;
  logic                          regRead;
  logic                          arrayWrite;
  logic                          transferError;
  logic                          protectHit;
  logic                          cmdBufEmpty;
  logic                          cmdComplete;
  logic                          statusWrite;
  logic                          launchWrite;
  logic                          abortWrite;
  logic                          launchOk;
  logic                          cmdWrite;
  logic                          cmdBad;
  logic                          arrayBad;
  logic                          handOver;
  logic                          verifyBlank;
  logic [fcsa_pkg::BYTE_W-1:0]   statusByte;
  logic [fcsa_pkg::BYTE_W-1:0]   configByte;
  logic [fcsa_pkg::DATA_W-1:0]   regData;

  assign regWrite   = bus.busReq && bus.busWrite && !bus.busArray;
  assign regRead    = bus.busReq && !bus.busWrite && !bus.busArray;
  assign arrayWrite = bus.busReq && bus.busWrite && bus.busArray && !transferError;

  fcsa_access_guard fcsa_access_guard_inst (
    .accessAddr    (bus.busAddr),
    .accessArray   (bus.busArray),
    .accessProgram (bus.busProgram),
    .dataMap       (dataMap_reg),
    .protectMap    (sectorProtect),
    .cmdCode       (bus.busWdata[fcsa_pkg::CMD_W-1:0]),
    .cmdAddr       (bufAddr_reg),
    .transferError (transferError),
    .protectHit    (protectHit)
  );

  assign cmdBufEmpty = (seq_reg != SEQ_HELD);
  assign cmdComplete = !engineBusy_reg && (seq_reg != SEQ_HELD);

  assign statusWrite = regWrite && (bus.busAddr == fcsa_pkg::OFS_USER_STATUS);
  assign launchWrite = statusWrite && bus.busWdata[fcsa_pkg::ST_CMD_BUF_EMPTY];
  assign abortWrite  = statusWrite && !bus.busWdata[fcsa_pkg::ST_CMD_BUF_EMPTY] &&
                       ((seq_reg == SEQ_DATA) || (seq_reg == SEQ_CMD));
  // A raised error flag blocks launch; the sequence waits until a status write with bit seven zero aborts it
  assign launchOk    = launchWrite && (seq_reg == SEQ_CMD) && !access_error_flag_reg && !protViol_reg;
  assign cmdWrite    = regWrite && (bus.busAddr == fcsa_pkg::OFS_COMMAND_CODE) && cmdBufEmpty;
  assign cmdBad      = cmdWrite && ((seq_reg != SEQ_DATA) ||
                       !fcsa_pkg::isValidCmd(bus.busWdata[fcsa_pkg::CMD_W-1:0]));
  assign arrayBad    = arrayWrite && (seq_reg != SEQ_EMPTY);
  assign handOver    = (seq_reg == SEQ_HELD) && (!engineBusy_reg || flashDone);
  assign verifyBlank = flashDone && fcsa_pkg::isVerifyCmd(engCmd_reg) && flashBlank;

  // Reset image of the map is read through the array port
  assign arrayLoadReq = loadPending_reg;
  assign arrayRdAddr  = loadPending_reg ? fcsa_pkg::MAP_LOAD_OFFSET : bus.busAddr;

  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      loadPending_reg <= 1'b1;
      dataMap_reg     <= fcsa_pkg::ZERO_WORD;
    end else if (loadPending_reg) begin
      loadPending_reg <= 1'b0;
      dataMap_reg     <= arrayRdData;
    end else if (regWrite && (bus.busAddr == fcsa_pkg::OFS_DATA_SPACE_MAP) && !lock_reg) begin
      dataMap_reg     <= bus.busWdata;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      lock_reg     <= 1'b0;
      cbeIrqEn_reg <= 1'b0;
      ccIrqEn_reg  <= 1'b0;
    end else if (regWrite && (bus.busAddr == fcsa_pkg::OFS_MODULE_CONFIG)) begin
      lock_reg     <= bus.busWdata[fcsa_pkg::CFG_LOCK];
      cbeIrqEn_reg <= bus.busWdata[fcsa_pkg::CFG_CBE_IRQ_EN];
      ccIrqEn_reg  <= bus.busWdata[fcsa_pkg::CFG_CC_IRQ_EN];
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      seq_reg     <= SEQ_EMPTY;
      cmdCode_reg <= '0;
      bufAddr_reg <= '0;
      bufData_reg <= fcsa_pkg::ZERO_WORD;
    end else begin
      case (seq_reg)
        SEQ_EMPTY: begin
          if (arrayWrite) begin
            bufAddr_reg <= bus.busAddr;
            bufData_reg <= bus.busWdata;
            seq_reg     <= SEQ_DATA;
          end
        end
        SEQ_DATA: begin
          if (abortWrite || arrayBad || cmdBad || launchWrite) begin
            seq_reg <= SEQ_EMPTY;
          end else if (cmdWrite) begin
            cmdCode_reg <= bus.busWdata[fcsa_pkg::CMD_W-1:0];
            seq_reg     <= protectHit ? SEQ_EMPTY : SEQ_CMD;
          end
        end
        SEQ_CMD: begin
          if (abortWrite || arrayBad || cmdBad) begin
            seq_reg <= SEQ_EMPTY;
          end else if (launchOk) begin
            seq_reg <= SEQ_HELD;
          end
        end
        SEQ_HELD: begin
          if (handOver) begin
            seq_reg <= SEQ_EMPTY;
          end
        end
        default: seq_reg <= SEQ_EMPTY;
      endcase
    end
  end

  // Set terms are ORed after the clear so a same-cycle event survives
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      access_error_flag_reg <= 1'b0;
    end else begin
      access_error_flag_reg <= (access_error_flag_reg && !(statusWrite && bus.busWdata[fcsa_pkg::ST_ACCESS_ERR])) ||
                    abortWrite || arrayBad || cmdBad ||
                    (launchWrite && (seq_reg == SEQ_DATA));
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      protViol_reg <= 1'b0;
    end else begin
      protViol_reg <= (protViol_reg && !(statusWrite && bus.busWdata[fcsa_pkg::ST_PROTECT_VIOL])) ||
                      (cmdWrite && !cmdBad && protectHit);
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      blank_reg <= 1'b0;
    end else begin
      blank_reg <= (blank_reg && !(statusWrite && bus.busWdata[fcsa_pkg::ST_BLANK])) || verifyBlank;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      engineBusy_reg <= 1'b0;
      start_reg      <= 1'b0;
      engCmd_reg     <= '0;
      engAddr_reg    <= '0;
      engData_reg    <= fcsa_pkg::ZERO_WORD;
    end else begin
      start_reg <= handOver;
      if (handOver) begin
        engineBusy_reg <= 1'b1;
        engCmd_reg     <= cmdCode_reg;
        engData_reg    <= bufData_reg;
        if (cmdCode_reg == fcsa_pkg::CMD_PAGE_ERASE) begin
          engAddr_reg <= {bufAddr_reg[fcsa_pkg::ADDR_W-1:fcsa_pkg::PAGE_LSB], {fcsa_pkg::PAGE_LSB{1'b0}}};
        end else begin
          engAddr_reg <= bufAddr_reg;
        end
      end else if (flashDone) begin
        engineBusy_reg <= 1'b0;
      end
    end
  end

  assign flashStart = start_reg;
  assign flashCmd   = engCmd_reg;
  assign flashAddr  = engAddr_reg;
  assign flashData  = engData_reg;

  always_comb begin
    statusByte = '0;
    statusByte[fcsa_pkg::ST_CMD_BUF_EMPTY] = cmdBufEmpty;
    statusByte[fcsa_pkg::ST_CMD_COMPLETE]  = cmdComplete;
    statusByte[fcsa_pkg::ST_PROTECT_VIOL]  = protViol_reg;
    statusByte[fcsa_pkg::ST_ACCESS_ERR]    = access_error_flag_reg;
    statusByte[fcsa_pkg::ST_BLANK]         = blank_reg;
    configByte = '0;
    configByte[fcsa_pkg::CFG_CBE_IRQ_EN] = cbeIrqEn_reg;
    configByte[fcsa_pkg::CFG_CC_IRQ_EN]  = ccIrqEn_reg;
    configByte[fcsa_pkg::CFG_LOCK]       = lock_reg;
  end

  always_comb begin
    case (bus.busAddr)
      fcsa_pkg::OFS_DATA_SPACE_MAP: regData = dataMap_reg;
      fcsa_pkg::OFS_USER_STATUS:    regData = {24'h000000, statusByte};
      fcsa_pkg::OFS_COMMAND_CODE:   regData = {25'h0000000, cmdCode_reg};
      fcsa_pkg::OFS_MODULE_CONFIG:  regData = {24'h000000, configByte};
      default:                      regData = fcsa_pkg::ZERO_WORD;
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      ack_reg   <= 1'b0;
      err_reg   <= 1'b0;
      rdata_reg <= fcsa_pkg::ZERO_WORD;
    end else begin
      ack_reg <= bus.busReq;
      err_reg <= bus.busReq && bus.busArray && transferError;
      if (regRead) begin
        rdata_reg <= regData;
      end else if (bus.busReq && bus.busArray && !bus.busWrite && !transferError) begin
        rdata_reg <= arrayRdData;
      end else begin
        rdata_reg <= fcsa_pkg::ZERO_WORD;
      end
    end
  end

  assign bus.busAck   = ack_reg;
  assign bus.busError = err_reg;
  assign bus.busRdata = rdata_reg;
  assign bus.irqReq   = (cmdBufEmpty && cbeIrqEn_reg) ||
                        (cmdComplete && ccIrqEn_reg);
endmodule // fcsa_device_end

//--- hdl/fcsa_pkg.sv
package fcsa_pkg;
  localparam int ADDR_W = 19;
  localparam int DATA_W = 32;
  localparam int CMD_W = 7;
  localparam int BYTE_W = 8;
  localparam int SECTOR_LSB = 14;
  localparam int SECTOR_W = 5;
  localparam int PAGE_LSB = 10;

  // Register space offsets of the flash module, and the array offset of the reset map image
  localparam logic [ADDR_W-1:0] OFS_DATA_SPACE_MAP = 19'h00000;
  localparam logic [ADDR_W-1:0] OFS_USER_STATUS = 19'h00004;
  localparam logic [ADDR_W-1:0] OFS_COMMAND_CODE = 19'h00008;
  localparam logic [ADDR_W-1:0] OFS_MODULE_CONFIG = 19'h0000C;
  localparam logic [ADDR_W-1:0] MAP_LOAD_OFFSET = 19'h00410;

  // User status bits
  localparam int ST_CMD_BUF_EMPTY = 7;
  localparam int ST_CMD_COMPLETE = 6;
  localparam int ST_PROTECT_VIOL = 5;
  localparam int ST_ACCESS_ERR = 4;
  localparam int ST_BLANK = 2;

  // Module config bits
  localparam int CFG_CBE_IRQ_EN = 7;
  localparam int CFG_CC_IRQ_EN = 6;
  localparam int CFG_LOCK = 0;

  localparam logic [CMD_W-1:0] CMD_ERASE_VERIFY_ALL_ONES = 7'h05;
  localparam logic [CMD_W-1:0] CMD_PAGE_ERASE_VERIFY = 7'h06;
  localparam logic [CMD_W-1:0] CMD_LONGWORD_PROGRAM = 7'h20;
  localparam logic [CMD_W-1:0] CMD_PAGE_ERASE = 7'h40;
  localparam logic [CMD_W-1:0] CMD_MASS_ERASE = 7'h41;

  localparam logic [DATA_W-1:0] ZERO_WORD = 32'h00000000;
  localparam logic [DATA_W-1:0] LAUNCH_WORD = 32'h00000080;

  // Host software port
  localparam int HOST_IDX_W = 3;
  localparam logic [HOST_IDX_W-1:0] HREG_ADDR = 3'h0;
  localparam logic [HOST_IDX_W-1:0] HREG_WDATA = 3'h1;
  localparam logic [HOST_IDX_W-1:0] HREG_CODE = 3'h2;
  localparam logic [HOST_IDX_W-1:0] HREG_CTRL = 3'h3;
  localparam logic [HOST_IDX_W-1:0] HREG_RDATA = 3'h4;
  localparam logic [HOST_IDX_W-1:0] HREG_STATUS = 3'h5;
  localparam int HC_WRITE = 0;
  localparam int HC_READ = 1;
  localparam int HC_ARRAY = 2;
  localparam int HC_PROGRAM = 3;
  localparam int HC_SEQUENCE = 4;
  localparam int HS_BUSY = 0;
  localparam int HS_ERROR = 1;
  localparam int HS_IRQ = 2;

  function automatic logic isValidCmd(input logic [CMD_W-1:0] code);
    return (code == CMD_ERASE_VERIFY_ALL_ONES) || (code == CMD_PAGE_ERASE_VERIFY) ||
           (code == CMD_LONGWORD_PROGRAM) || (code == CMD_PAGE_ERASE) || (code == CMD_MASS_ERASE);
  endfunction

  function automatic logic isVerifyCmd(input logic [CMD_W-1:0] code);
    return (code == CMD_ERASE_VERIFY_ALL_ONES) || (code == CMD_PAGE_ERASE_VERIFY);
  endfunction

  function automatic logic [SECTOR_W-1:0] sectorOf(input logic [ADDR_W-1:0] addr);
    return addr[SECTOR_LSB +: SECTOR_W];
  endfunction
endpackage

//--- hdl/fcsa_bus_if.sv
`timescale 1ns/10ps
interface fcsa_bus_if;
  logic                             busReq;
  logic                             busWrite;
  logic                             busArray;
  logic                             busProgram;
  logic [fcsa_pkg::ADDR_W-1:0]      busAddr;
  logic [fcsa_pkg::DATA_W-1:0]      busWdata;
  logic [fcsa_pkg::DATA_W-1:0]      busRdata;
  logic                             busAck;
  logic                             busError;
  logic                             irqReq;

  modport device (
    input  busReq,
    input  busWrite,
    input  busArray,
    input  busProgram,
    input  busAddr,
    input  busWdata,
    output busRdata,
    output busAck,
    output busError,
    output irqReq
  );

  modport host (
    output busReq,
    output busWrite,
    output busArray,
    output busProgram,
    output busAddr,
    output busWdata,
    input  busRdata,
    input  busAck,
    input  busError,
    input  irqReq
  );
endinterface

//--- hdl/fcsa_access_guard.sv
`timescale 1ns/10ps
module fcsa_access_guard (
  input  wire logic [fcsa_pkg::ADDR_W-1:0] accessAddr,
  input  wire logic                        accessArray,
  input  wire logic                        accessProgram,
  input  wire logic [fcsa_pkg::DATA_W-1:0] dataMap,
  input  wire logic [fcsa_pkg::DATA_W-1:0] protectMap,
  input  wire logic [fcsa_pkg::CMD_W-1:0]  cmdCode,
  input  wire logic [fcsa_pkg::ADDR_W-1:0] cmdAddr,
  output logic                             transferError,
  output logic                             protectHit
);
  logic cmdSectorProt;

  // Data-only sectors refuse program fetches; mixed sectors take both
  assign transferError = accessArray && accessProgram && dataMap[fcsa_pkg::sectorOf(accessAddr)];

  assign cmdSectorProt = protectMap[fcsa_pkg::sectorOf(cmdAddr)];

  always_comb begin
    case (cmdCode)
      fcsa_pkg::CMD_LONGWORD_PROGRAM: protectHit = cmdSectorProt;
      fcsa_pkg::CMD_PAGE_ERASE:       protectHit = cmdSectorProt;
      // Mass erase touches every sector, so any protection blocks it
      fcsa_pkg::CMD_MASS_ERASE:       protectHit = |protectMap;
      default:                        protectHit = 1'b0;
    endcase
  end
endmodule // fcsa_access_guard

//--- hdl/fcsa_host_end.sv
`timescale 1ns/10ps
module fcsa_host_end (
  input  wire logic                            clk_sys,
  input  wire logic                            reset_n,
  fcsa_bus_if.host                             bus,
  input  wire logic [fcsa_pkg::HOST_IDX_W-1:0] swAddr,
  input  wire logic [fcsa_pkg::DATA_W-1:0]     swWdata,
  input  wire logic                            swWrite,
  input  wire logic                            swRead,
  output logic      [fcsa_pkg::DATA_W-1:0]     swRdata
);
  typedef enum logic [2:0] {H_IDLE, H_SINGLE, H_SEQ_ARRAY, H_SEQ_CMD, H_SEQ_LAUNCH} fcsa_host_type;

  fcsa_host_type                 state_reg;
  logic                          wait_reg;
  logic [fcsa_pkg::ADDR_W-1:0]   addr_reg;
  logic [fcsa_pkg::DATA_W-1:0]   wdata_reg;
  logic [fcsa_pkg::CMD_W-1:0]    code_reg;
  logic                          write_reg;
  logic                          array_reg;
  logic                          program_reg;
  logic                          error_reg;
  logic [fcsa_pkg::DATA_W-1:0]   rdata_reg;
  logic [fcsa_pkg::DATA_W-1:0]   swRdata_reg;
  logic                          ctrlWrite;
  logic                          idle;

  assign idle      = (state_reg == H_IDLE);
  // Orders arriving while a transfer runs are dropped
  assign ctrlWrite = swWrite && (swAddr == fcsa_pkg::HREG_CTRL) && idle;

  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      addr_reg  <= '0;
      wdata_reg <= fcsa_pkg::ZERO_WORD;
      code_reg  <= '0;
    end else if (swWrite && idle) begin
      if (swAddr == fcsa_pkg::HREG_ADDR) addr_reg <= swWdata[fcsa_pkg::ADDR_W-1:0];
      if (swAddr == fcsa_pkg::HREG_WDATA) wdata_reg <= swWdata;
      if (swAddr == fcsa_pkg::HREG_CODE) code_reg <= swWdata[fcsa_pkg::CMD_W-1:0];
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      state_reg   <= H_IDLE;
      wait_reg    <= 1'b0;
      write_reg   <= 1'b0;
      array_reg   <= 1'b0;
      program_reg <= 1'b0;
      error_reg   <= 1'b0;
      rdata_reg   <= fcsa_pkg::ZERO_WORD;
    end else if (idle) begin
      if (ctrlWrite && swWdata[fcsa_pkg::HC_SEQUENCE]) begin
        state_reg <= H_SEQ_ARRAY;
        error_reg <= 1'b0;
      end else if (ctrlWrite && (swWdata[fcsa_pkg::HC_WRITE] || swWdata[fcsa_pkg::HC_READ])) begin
        state_reg   <= H_SINGLE;
        write_reg   <= swWdata[fcsa_pkg::HC_WRITE];
        array_reg   <= swWdata[fcsa_pkg::HC_ARRAY];
        program_reg <= swWdata[fcsa_pkg::HC_PROGRAM];
        error_reg   <= 1'b0;
      end
    end else if (!wait_reg) begin
      wait_reg <= 1'b1;
    end else if (bus.busAck) begin
      wait_reg  <= 1'b0;
      rdata_reg <= bus.busRdata;
      error_reg <= bus.busError;
      // The three steps go back to back with no foreign write between
      case (state_reg)
        H_SEQ_ARRAY:  state_reg <= bus.busError ? H_IDLE : H_SEQ_CMD;
        H_SEQ_CMD:    state_reg <= H_SEQ_LAUNCH;
        default:      state_reg <= H_IDLE;
      endcase
    end
  end

  assign bus.busReq = !idle && !wait_reg;

  always_comb begin
    case (state_reg)
      H_SEQ_ARRAY: begin
        bus.busWrite = 1'b1; bus.busArray = 1'b1; bus.busProgram = 1'b0;
        bus.busAddr = addr_reg; bus.busWdata = wdata_reg;
      end
      H_SEQ_CMD: begin
        bus.busWrite = 1'b1; bus.busArray = 1'b0; bus.busProgram = 1'b0;
        bus.busAddr = fcsa_pkg::OFS_COMMAND_CODE; bus.busWdata = {25'h0000000, code_reg};
      end
      H_SEQ_LAUNCH: begin
        // Only the buffer-empty bit is written, no other flag is touched
        bus.busWrite = 1'b1; bus.busArray = 1'b0; bus.busProgram = 1'b0;
        bus.busAddr = fcsa_pkg::OFS_USER_STATUS; bus.busWdata = fcsa_pkg::LAUNCH_WORD;
      end
      default: begin
        bus.busWrite = write_reg; bus.busArray = array_reg; bus.busProgram = program_reg;
        bus.busAddr = addr_reg; bus.busWdata = wdata_reg;
      end
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      swRdata_reg <= fcsa_pkg::ZERO_WORD;
    end else if (swRead) begin
      case (swAddr)
        fcsa_pkg::HREG_ADDR:   swRdata_reg <= {13'h0000, addr_reg};
        fcsa_pkg::HREG_WDATA:  swRdata_reg <= wdata_reg;
        fcsa_pkg::HREG_CODE:   swRdata_reg <= {25'h0000000, code_reg};
        fcsa_pkg::HREG_RDATA:  swRdata_reg <= rdata_reg;
        fcsa_pkg::HREG_STATUS: swRdata_reg <= {29'h00000000, bus.irqReq, error_reg, !idle};
        default:               swRdata_reg <= fcsa_pkg::ZERO_WORD;
      endcase
    end else begin
      swRdata_reg <= fcsa_pkg::ZERO_WORD;
    end
  end

  assign swRdata = swRdata_reg;
endmodule // fcsa_host_end

//--- verification/fcsa_bus_assertions.sv
`timescale 1ns/10ps
module fcsa_bus_assertions (
  input wire logic                        clk_sys,
  input wire logic                        reset_n,
  input wire logic                        busReq,
  input wire logic                        busWrite,
  input wire logic                        busArray,
  input wire logic                        busProgram,
  input wire logic [fcsa_pkg::ADDR_W-1:0] busAddr,
  input wire logic [fcsa_pkg::DATA_W-1:0] busRdata,
  input wire logic                        busAck,
  input wire logic                        busError,
  input wire logic                        irqReq
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!reset_n);
  // Reads hit config offsets only in register space
  chk_ack_one_cycle: assert property (busReq |=> busAck) else $error("ack missing");
  chk_no_stray_ack: assert property (
    !busReq |=> !busAck && busRdata == '0) else $error("stray ack");
  chk_error_cause: assert property (
    busError |-> busAck && $past(busReq && busArray && busProgram)) else $error("error without program access");
  chk_data_no_error: assert property (
    busReq && !busProgram |=> !busError) else $error("data access faulted");
  chk_reg_write_ok: assert property (
    busReq && busWrite && !busArray |=> !busError) else $error("register write faulted");
  chk_cmd_top_zero: assert property (
    busReq && !busWrite && !busArray && busAddr == fcsa_pkg::OFS_COMMAND_CODE |=> busRdata[31:7] == '0)
    else $error("command bit seven set");
  chk_status_reserved: assert property (
    busReq && !busWrite && !busArray && busAddr == fcsa_pkg::OFS_USER_STATUS |=> (busRdata & 32'hFFFFFF0B) == '0)
    else $error("status reserved bits set");
  chk_irq_after_reset: assert property (
    $rose(reset_n) |-> !irqReq [*2]) else $error("irq after reset");
endmodule // fcsa_bus_assertions

//--- verification/tb_top.sv
`timescale 1ns/10ps
module tb_top;
  logic        clk_sys = 1'b0;
  logic        reset_n = 1'b0;
  logic [2:0]  swAddr = 3'h0;
  logic [31:0] swWdata = 32'h0, swRdata, arrayRdData, flashData, sectorProtect = 32'h0;
  logic        swWrite = 1'b0, swRead = 1'b0, flashStart, flashDone = 1'b0, flashBlank = 1'b1, arrayLoadReq;
  logic [18:0] arrayRdAddr, flashAddr, lastAddr;
  logic [6:0]  flashCmd, lastCmd;
  logic [7:0]  codes [4] = '{8'h05, 8'h06, 8'h40, 8'h41};
  int          n_fail = 0, tests_run = 0, nStart = 0, n0;
  always #2 clk_sys = ~clk_sys;
  // Map word at the load offset marks sector 1 data-only
  assign arrayRdData = (arrayRdAddr == fcsa_pkg::MAP_LOAD_OFFSET) ? 32'h00000002 : 32'hFFFFFFFF;
  // Engine finishes one cycle after each start
  always @(posedge clk_sys) begin
    flashDone <= flashStart;
    if (flashStart === 1'b1) begin
      nStart <= nStart + 1;
      lastCmd <= flashCmd;
      lastAddr <= flashAddr;
    end
  end
  fcsa_bus_if fcsa_bus_if_inst ();
  fcsa_device_end fcsa_device_end_inst (.clk_sys, .reset_n, .bus(fcsa_bus_if_inst), .sectorProtect, .arrayRdAddr,
    .arrayRdData, .arrayLoadReq, .flashStart, .flashCmd, .flashAddr, .flashData, .flashDone, .flashBlank);
  fcsa_host_end fcsa_host_end_inst (.clk_sys, .reset_n, .bus(fcsa_bus_if_inst), .swAddr, .swWdata, .swWrite,
    .swRead, .swRdata);
  fcsa_bus_assertions fcsa_bus_assertions_inst (.clk_sys, .reset_n, .busReq(fcsa_bus_if_inst.busReq),
    .busWrite(fcsa_bus_if_inst.busWrite), .busArray(fcsa_bus_if_inst.busArray),
    .busProgram(fcsa_bus_if_inst.busProgram), .busAddr(fcsa_bus_if_inst.busAddr),
    .busRdata(fcsa_bus_if_inst.busRdata), .busAck(fcsa_bus_if_inst.busAck),
    .busError(fcsa_bus_if_inst.busError), .irqReq(fcsa_bus_if_inst.irqReq));
  task check(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_fail++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task sw(input logic [2:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    swAddr <= a; swWdata <= d; swWrite <= 1'b1;
    @(posedge clk_sys);
    swWrite <= 1'b0;
  endtask
  // Fixed wait covers the three-step sequence walk
  task op(input logic [31:0] addr, input logic [31:0] d, input logic [31:0] ctrl);
    sw(3'h0, addr); sw(3'h1, d); sw(3'h3, ctrl);
    repeat (12) @(posedge clk_sys);
  endtask
  task rd(input logic [2:0] a, input logic [31:0] exp, input logic [31:0] mask);
    @(posedge clk_sys);
    swAddr <= a; swRead <= 1'b1;
    @(posedge clk_sys);
    swRead <= 1'b0;
    #1 check(swRdata & mask, exp);
  endtask
  task reg_chk(input logic [31:0] ofs, input logic [31:0] exp);
    op(ofs, 32'h0, 32'h2); rd(3'h4, exp, 32'hFFFFFFFF);
  endtask
  task end_of_test;
    $display("errors %0d checks %0d", n_fail, tests_run);
    if (n_fail == 0 && tests_run > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  initial begin
    #100000 n_fail++;
    end_of_test;
  end
  initial begin
    repeat (8) @(posedge clk_sys);
    reset_n <= 1'b1;
    repeat (3) @(posedge clk_sys);
    check({31'h0, arrayLoadReq}, 32'h0);
    reg_chk(fcsa_pkg::OFS_DATA_SPACE_MAP, 32'h2);
    reg_chk(fcsa_pkg::OFS_USER_STATUS, 32'hC0);
    op(fcsa_pkg::OFS_DATA_SPACE_MAP, 32'h3, 32'h1);
    op(fcsa_pkg::OFS_MODULE_CONFIG, 32'h1, 32'h1);
    op(fcsa_pkg::OFS_DATA_SPACE_MAP, 32'h0, 32'h1);
    reg_chk(fcsa_pkg::OFS_DATA_SPACE_MAP, 32'h3);
    op(fcsa_pkg::OFS_MODULE_CONFIG, 32'h0, 32'h1);
    op(32'h04000, 32'h0, 32'hE); rd(3'h5, 32'h2, 32'h2);
    op(32'h04000, 32'h0, 32'h6); rd(3'h5, 32'h0, 32'h2);
    op(32'h08000, 32'h0, 32'hE); rd(3'h5, 32'h0, 32'h2);
    op(32'h04400, 32'h12345678, 32'h5);
    op(fcsa_pkg::OFS_COMMAND_CODE, 32'hA0, 32'h1);
    reg_chk(fcsa_pkg::OFS_COMMAND_CODE, 32'h20);
    op(fcsa_pkg::OFS_USER_STATUS, 32'h80, 32'h1);
    check({25'h0, lastCmd}, 32'h20);
    check({13'h0, lastAddr}, 32'h04400);
    check(flashData, 32'h12345678);
    foreach (codes[i]) begin
      sw(3'h2, {24'h0, codes[i]});
      op(32'h083FC, 32'h0, 32'h10);
      check({25'h0, lastCmd}, {24'h0, codes[i]});
      if (codes[i] == 8'h40) check({13'h0, lastAddr}, 32'h08000);
      reg_chk(fcsa_pkg::OFS_USER_STATUS, (codes[i] < 8'h10) ? 32'hC4 : 32'hC0);
      op(fcsa_pkg::OFS_USER_STATUS, 32'h04, 32'h1);
      reg_chk(fcsa_pkg::OFS_USER_STATUS, 32'hC0);
    end
    // A verify that finds programmed cells must leave blank clear
    @(posedge clk_sys) flashBlank <= 1'b0;
    sw(3'h2, 32'h05); op(32'h083FC, 32'h0, 32'h10);
    reg_chk(fcsa_pkg::OFS_USER_STATUS, 32'hC0);
    @(posedge clk_sys) sectorProtect <= 32'hFFFFFFFF;
    n0 = nStart;
    sw(3'h2, 32'h20); op(32'h0C000, 32'h0, 32'h10);
    reg_chk(fcsa_pkg::OFS_USER_STATUS, 32'hE0);
    // Unprotected target, so only the raised violation flag can stop it
    @(posedge clk_sys) sectorProtect <= 32'h0;
    op(32'h0C000, 32'h0, 32'h10);
    check(nStart, n0);
    op(fcsa_pkg::OFS_USER_STATUS, 32'h20, 32'h1);
    reg_chk(fcsa_pkg::OFS_USER_STATUS, 32'hD0);
    op(fcsa_pkg::OFS_USER_STATUS, 32'h10, 32'h1);
    sw(3'h2, 32'h7F); op(32'h0C000, 32'h0, 32'h10);
    reg_chk(fcsa_pkg::OFS_USER_STATUS, 32'hD0);
    sw(3'h2, 32'h20); op(32'h0C000, 32'h0, 32'h10);
    check(nStart, n0);
    op(fcsa_pkg::OFS_USER_STATUS, 32'h10, 32'h1);
    reg_chk(fcsa_pkg::OFS_USER_STATUS, 32'hD0);
    op(fcsa_pkg::OFS_USER_STATUS, 32'h10, 32'h1);
    reg_chk(fcsa_pkg::OFS_USER_STATUS, 32'hC0);
    check({31'h0, fcsa_bus_if_inst.irqReq}, 32'h0);
    op(fcsa_pkg::OFS_MODULE_CONFIG, 32'h80, 32'h1);
    check({31'h0, fcsa_bus_if_inst.irqReq}, 32'h1);
    op(fcsa_pkg::OFS_MODULE_CONFIG, 32'h40, 32'h1);
    check({31'h0, fcsa_bus_if_inst.irqReq}, 32'h1);
    end_of_test;
  end
endmodule // tb_top
